// >>> fig_glue.sv
// Floppy interface glue: clocks, precompensation, read path, address bit
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Primary mode: core clock 8 MHz at 500k rate, 4 MHz at 250k.
// - Write clock toggles at twice the bit rate: 1 MHz or 500 kHz.
// - Primary mode: raw write stream passes precompensation, driven active low to drive.
// - Alternate mode: drive write output is just the inverted raw write stream.
// - Two select inputs pick write shift; grounded in alternate mode.
// - Active-low drive read stream is buffered to the controller; unused in alternate.
// - VCO input divided by 4 at 500k, by 8 at 250k, as feedback.
// - PLL reference runs 1 MHz at 500k, 500 kHz at 250k.
// - Data window sample period 1 us at 500k, 2 us at 250k.
// - Alternate mode: capture status bit 1 on latch strobe rising edge for address bit 0.
// - Controller select asserted low on I/O access to 03F4H or 03F5H.
// - Primary mode clocks derive from 16 MHz two-phase source; tied high otherwise.
module fig_glue (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       mode_alt_i,
	input  wire logic       density_select_i,
	input  wire logic       source_clock_phase_a_i,
	input  wire logic       source_clock_phase_b_i,
	input  wire logic       vco_input_i,
	input  wire logic       raw_write_stream_i,
	input  wire logic       drive_read_stream_n_i,
	input  wire logic       address_latch_strobe_n_i,
	input  wire logic       channel_status1_n_i,
	input  wire logic       disk_write_gate_i,
	input  wire logic       precomp_select_lo_i,
	input  wire logic       precomp_select_hi_i,
	input  wire logic       read_stream_valid_i,
	input  wire logic       io_access_i,
	input  wire logic [9:0] io_addr_i,
	output logic            fdc_core_clock_out_o,
	output logic            fdc_write_clock_o,
	output logic            drive_write_stream_n_o,
	output logic            buffered_read_stream_o,
	output logic            vco_divided_feedback_o,
	output logic            pll_reference_clock_o,
	output logic            data_window_o,
	output logic            aux_address_bit0_o,
	output logic            controller_select_n_o,
	output logic            precomp_ready_o
);
	localparam int N = fig_pkg::NPIN;

	typedef enum logic [1:0] {PG_IDLE, PG_WAIT, PG_PULSE} fig_pg_t;

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] f;
		logic [N-1:0] fd;
		logic         mode;
		logic         rate;
		logic [4:0]   src_cnt;
		logic [2:0]   vco_cnt;
		logic [fig_pkg::BUF_DEPTH-1:0][1:0] buf_mem;
		logic         wp;
		logic         rp;
		logic [1:0]   cnt;
		logic         ready;
		fig_pg_t      pg;
		logic [5:0]   pg_cnt;
		logic         dir;
		logic         core;
		logic         wclk;
		logic         wr_n;
		logic         rd;
		logic         fb;
		logic         ref_clk;
		logic         win;
		logic         aux;
		logic         sel_n;
	} fig_state_t;

	fig_state_t q;
	fig_state_t next_q;
	logic [N-1:0] pins;

	// Shift in cycles for a precompensation code
	function automatic logic [5:0] fig_delay(input logic [1:0] code);
		logic [5:0] r;
		r = 6'(fig_pkg::PRECOMP_STEP_CYC);
		if (code == fig_pkg::PC_EARLY) begin
			r = 6'h00;
		end else if (code == fig_pkg::PC_LATE) begin
			r = 6'(2 * fig_pkg::PRECOMP_STEP_CYC);
		end
		return r;
	endfunction

	always_comb begin
		pins = '0;
		pins[fig_pkg::P_SRC_A] = source_clock_phase_a_i;
		pins[fig_pkg::P_SRC_B] = source_clock_phase_b_i;
		pins[fig_pkg::P_VCO]   = vco_input_i;
		pins[fig_pkg::P_WR]    = raw_write_stream_i;
		pins[fig_pkg::P_RD_N]  = drive_read_stream_n_i;
		pins[fig_pkg::P_STB_N] = address_latch_strobe_n_i;
		pins[fig_pkg::P_ST1_N] = channel_status1_n_i;
		pins[fig_pkg::P_GATE]  = disk_write_gate_i;
		pins[fig_pkg::P_PC_LO] = precomp_select_lo_i;
		pins[fig_pkg::P_PC_HI] = precomp_select_hi_i;
		pins[fig_pkg::P_VALID] = read_stream_valid_i;
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [N-1:0] rise;
		logic         restart;
		logic         push;
		logic         pop;
		logic [1:0]   code;
		rise    = '0;
		restart = 1'b0;
		push    = 1'b0;
		pop     = 1'b0;
		code    = fig_pkg::PC_NONE;
		next_q  = q;

		// Three-stage sync; a level counts once stages two and three agree
		next_q.s1 = pins;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		for (int i = 0; i < N; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				next_q.f[i] = q.s3[i];
			end
		end
		next_q.fd = q.f;
		rise = q.f & ~q.fd;

		next_q.mode = mode_alt_i;
		next_q.rate = density_select_i;
		restart = (q.mode != mode_alt_i) || (q.rate != density_select_i);

		if (rise[fig_pkg::P_SRC_A] && !q.f[fig_pkg::P_SRC_B]) begin
			next_q.src_cnt = q.src_cnt + 5'h01;
		end
		if (rise[fig_pkg::P_VCO]) begin
			next_q.vco_cnt = q.vco_cnt + 3'h1;
		end
		if (restart || q.mode) begin
			next_q.src_cnt = 5'h00;
			next_q.vco_cnt = 3'h0;
		end

		next_q.core = q.rate ? q.src_cnt[0] : q.src_cnt[1];
		next_q.wclk = q.rate ? q.src_cnt[3] : q.src_cnt[4];
		next_q.ref_clk = q.rate ? q.src_cnt[3] : q.src_cnt[4];
		// data window period follows bit rate
		next_q.win = q.rate ? q.src_cnt[3] : q.src_cnt[4];
		next_q.fb = q.rate ? q.vco_cnt[1] : q.vco_cnt[2];
		next_q.rd = ~q.f[fig_pkg::P_RD_N];

		// capture status on strobe trailing edge
		if (rise[fig_pkg::P_STB_N]) begin
			next_q.dir = q.f[fig_pkg::P_ST1_N];
		end
		next_q.aux = q.mode ? q.dir : 1'b0;

		next_q.sel_n = !(io_access_i && (io_addr_i[9:1] == fig_pkg::SEL_ADDR[9:1]));

		////////////////////////////////////////////////////////////////////////
		// Write edges queue up to two deep behind a pulse still in flight; edges arriving while full are dropped
		// select bits give the shift code
		code = {q.f[fig_pkg::P_PC_HI], q.f[fig_pkg::P_PC_LO]};
		// Gate taken as qualifier; the controller keeps it low when idle
		push = !q.mode && rise[fig_pkg::P_WR] && q.f[fig_pkg::P_GATE] && q.ready;
		pop  = (q.pg == PG_IDLE) && (q.cnt != 2'h0) && !q.mode;
		if (push) begin
			next_q.buf_mem[q.wp] = code;
			next_q.wp = ~q.wp;
		end
		if (pop) begin
			next_q.rp = ~q.rp;
		end
		next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

		unique case (q.pg)
			PG_IDLE: begin
				if (pop) begin
					next_q.pg_cnt = fig_delay(q.buf_mem[q.rp]);
					next_q.pg = PG_WAIT;
				end
			end
			PG_WAIT: begin
				if (q.pg_cnt == 6'h00) begin
					next_q.pg_cnt = 6'(fig_pkg::WR_PULSE_CYC - 1);
					next_q.wr_n = 1'b0;
					next_q.pg = PG_PULSE;
				end else begin
					next_q.pg_cnt = q.pg_cnt - 6'h01;
				end
			end
			PG_PULSE: begin
				if (q.pg_cnt == 6'h00) begin
					next_q.wr_n = 1'b1;
					next_q.pg = PG_IDLE;
				end else begin
					next_q.pg_cnt = q.pg_cnt - 6'h01;
				end
			end
		endcase

		if (q.mode) begin
			next_q.wr_n = ~q.f[fig_pkg::P_WR];
			next_q.pg = PG_IDLE;
			next_q.wp = 1'b0;
			next_q.rp = 1'b0;
			next_q.cnt = 2'h0;
			next_q.core = 1'b0;
			next_q.wclk = 1'b0;
			next_q.ref_clk = 1'b0;
			next_q.win = 1'b0;
			next_q.fb = 1'b0;
			next_q.rd = 1'b0;
		end else if (restart) begin
			next_q.wr_n = 1'b1;
			next_q.pg = PG_IDLE;
		end
		next_q.ready = (next_q.cnt != 2'(fig_pkg::BUF_DEPTH));
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.s1 <= fig_pkg::PIN_RST;
			q.s2 <= fig_pkg::PIN_RST;
			q.s3 <= fig_pkg::PIN_RST;
			q.f <= fig_pkg::PIN_RST;
			q.fd <= fig_pkg::PIN_RST;
			q.pg <= PG_IDLE;
			q.ready <= 1'b1;
			q.wr_n <= 1'b1;
			q.sel_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign fdc_core_clock_out_o   = q.core;
	assign fdc_write_clock_o      = q.wclk;
	assign drive_write_stream_n_o = q.wr_n;
	assign buffered_read_stream_o = q.rd;
	assign vco_divided_feedback_o = q.fb;
	assign pll_reference_clock_o  = q.ref_clk;
	assign data_window_o          = q.win;
	assign aux_address_bit0_o     = q.aux;
	assign controller_select_n_o  = q.sel_n;
	assign precomp_ready_o        = q.ready;
endmodule

`default_nettype wire

// >>> fig_pkg.sv
// Package of constants for the floppy interface glue logic
package fig_pkg;
	// Synchronised pin indices
	localparam int P_SRC_A  = 0;
	localparam int P_SRC_B  = 1;
	localparam int P_VCO    = 2;
	localparam int P_WR     = 3;
	localparam int P_RD_N   = 4;
	localparam int P_STB_N  = 5;
	localparam int P_ST1_N  = 6;
	localparam int P_GATE   = 7;
	localparam int P_PC_LO  = 8;
	localparam int P_PC_HI  = 9;
	localparam int P_VALID  = 10;
	localparam int NPIN     = 11;

	// Controller select decode, ports 03F4H and 03F5H
	localparam logic [9:0] SEL_ADDR = 10'h3F4;

	// Timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int WR_PULSE_NS     = 350;
	localparam int PRECOMP_STEP_NS = 125;
	localparam int WR_PULSE_CYC    = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECOMP_STEP_CYC = (PRECOMP_STEP_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(PRECOMP_STEP_NS / CLK_PERIOD_NS);

	// Precompensation codes {hi, lo}
	localparam logic [1:0] PC_NONE  = 2'h0;
	localparam logic [1:0] PC_EARLY = 2'h1;
	localparam logic [1:0] PC_LATE  = 2'h2;

	// Buffer depth
	localparam int BUF_DEPTH = 2;

	// Reset values: idle levels, so that no false edge follows reset
	localparam logic [NPIN-1:0] PIN_RST = 11'h070;
endpackage

// >>> fig_glue_props.sv
// Port checker for the floppy glue
`timescale 1ns/1ps
`default_nettype none
module fig_glue_props (
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic       mode_alt_i,
	input wire logic       raw_write_stream_i,
	input wire logic       drive_read_stream_n_i,
	input wire logic       io_access_i,
	input wire logic [9:0] io_addr_i,
	input wire logic       fdc_core_clock_out_o,
	input wire logic       fdc_write_clock_o,
	input wire logic       drive_write_stream_n_o,
	input wire logic       buffered_read_stream_o,
	input wire logic       vco_divided_feedback_o,
	input wire logic       pll_reference_clock_o,
	input wire logic       data_window_o,
	input wire logic       aux_address_bit0_o,
	input wire logic       controller_select_n_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_sel; io_access_i && io_addr_i[9:1] == 9'h1FA |=> !controller_select_n_o; endproperty
	a_sel: assert property (p_sel) else $error("select missing");
	property p_idle; !io_access_i |=> controller_select_n_o; endproperty
	a_idle: assert property (p_idle) else $error("stray select");
	property p_alt_clk; mode_alt_i [*4] |-> !(fdc_core_clock_out_o | fdc_write_clock_o | pll_reference_clock_o |
		data_window_o | vco_divided_feedback_o); endproperty
	a_alt_clk: assert property (p_alt_clk) else $error("clock runs in alternate mode");
	property p_alt_rd; mode_alt_i [*4] |-> !buffered_read_stream_o; endproperty
	a_alt_rd: assert property (p_alt_rd) else $error("read output not static");
	property p_prim_aux; !mode_alt_i [*4] |-> !aux_address_bit0_o; endproperty
	a_prim_aux: assert property (p_prim_aux) else $error("aux bit in primary mode");
	property p_alt_wr; (mode_alt_i && $stable(raw_write_stream_i)) [*8] |->
		drive_write_stream_n_o == !raw_write_stream_i; endproperty
	a_alt_wr: assert property (p_alt_wr) else $error("write not inverted");
	property p_rd; (!mode_alt_i && $stable(drive_read_stream_n_i)) [*8] |->
		buffered_read_stream_o == !drive_read_stream_n_i; endproperty
	a_rd: assert property (p_rd) else $error("read not buffered");
	property p_pw; $fell(drive_write_stream_n_o) && !mode_alt_i |=> !drive_write_stream_n_o [*8]; endproperty
	a_pw: assert property (p_pw) else $error("write pulse short");
	c_pulse: cover property ($fell(drive_write_stream_n_o));
	c_sel: cover property (!controller_select_n_o);
	c_aux: cover property ($rose(aux_address_bit0_o));
endmodule
`default_nettype wire

// >>> fig_src_model.sv
// Source clock and VCO model at the far side
`timescale 1ns/1ps
`default_nettype none
module fig_src_model #(
	parameter real VCO_NS = 250.0
) (
	input  wire logic alt_i,
	output logic      src_a_o,
	output logic      src_b_o,
	output logic      vco_o
);
	// non-overlapping 16 MHz phases, tied high in alternate mode
	initial forever begin
		src_a_o = 1'b1;
		src_b_o = alt_i;
		#20;
		src_a_o = alt_i;
		#11.25;
		src_b_o = 1'b1;
		#20;
		src_b_o = alt_i;
		#11.25;
	end
	initial forever begin
		vco_o = ~alt_i;
		#(VCO_NS / 2.0);
		vco_o = 1'b0;
		#(VCO_NS / 2.0);
	end
endmodule
`default_nettype wire

// >>> floppy_interface_glue_test.sv
// Self-checking bench for the floppy glue
`timescale 1ns/1ps
`default_nettype none
bind fig_glue fig_glue_props i_fig_glue_props (.*);
module floppy_interface_glue_test;
	logic       clock_i;
	logic       rst_n_i = 1'b0, alt = 1'b0, dens = 1'b1, raw = 1'b0, rd_n = 1'b1, stb_n = 1'b1, st1_n = 1'b1;
	logic       gate = 1'b1, valid = 1'b1, acc = 1'b0;
	logic [1:0] pc = 2'h0;
	logic [9:0] addr = 10'h000;
	wire logic  src_a, src_b, vco, core, wrc, dwn, brd, fb, pref, dw, aux, sel_n, rdy;
	wire logic [4:0] o = {fb, dw, pref, wrc, core};
	int         fails = 0, compares = 0, cyc = 0, nf = 0, l[4];
	fig_src_model i_fig_src_model (.alt_i(alt), .src_a_o(src_a), .src_b_o(src_b), .vco_o(vco));
	fig_glue i_fig_glue (.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_alt_i(alt), .density_select_i(dens),
		.source_clock_phase_a_i(src_a), .source_clock_phase_b_i(src_b), .vco_input_i(vco),
		.raw_write_stream_i(raw), .drive_read_stream_n_i(rd_n), .address_latch_strobe_n_i(stb_n),
		.channel_status1_n_i(st1_n), .disk_write_gate_i(gate), .precomp_select_lo_i(pc[0]),
		.precomp_select_hi_i(pc[1]), .read_stream_valid_i(valid), .io_access_i(acc), .io_addr_i(addr),
		.fdc_core_clock_out_o(core), .fdc_write_clock_o(wrc), .drive_write_stream_n_o(dwn),
		.buffered_read_stream_o(brd), .vco_divided_feedback_o(fb), .pll_reference_clock_o(pref),
		.data_window_o(dw), .aux_address_bit0_o(aux), .controller_select_n_o(sel_n), .precomp_ready_o(rdy));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	always @(negedge dwn) nf++;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	task automatic results;
		$display("Mismatches %0d of %0d comparisons", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n); repeat (n) @(posedge clock_i); endtask
	// Outputs are looked at on the falling edge, where they have settled
	task automatic tock(input int n); repeat (n) @(negedge clock_i); endtask
	task automatic edge_of(input int w);
		logic p;
		do begin
			p = o[w];
			tock(1);
		end while (!(o[w] === 1'b1 && p === 1'b0));
	endtask
	// Four periods averaged, since sampling the source adds a few cycles of jitter
	task automatic per(input int w, input real e);
		real t0;
		edge_of(w);
		t0 = $realtime;
		repeat (4) edge_of(w);
		check(($realtime - t0) / 4.0 > e * 0.85 && ($realtime - t0) / 4.0 < e * 1.15, 1);
	endtask
	task automatic t_clk(input logic d);
		tick(1);
		dens <= d;
		tick(20);
		per(0, d ? 125.0 : 250.0);
		for (int w = 1; w < 5; w++) per(w, d ? 1000.0 : 2000.0);
	endtask
	task automatic pulse;
		tick(1);
		raw <= 1'b1;
		tick(4);
		raw <= 1'b0;
		tick(4);
	endtask
	task automatic lat(input logic [1:0] code, output int n);
		int w;
		tick(1);
		pc <= code;
		tick(8);
		raw <= 1'b1;
		n = 0;
		w = 0;
		while (dwn !== 1'b0 && n < 200) begin
			tock(1);
			n++;
		end
		while (dwn === 1'b0 && w < 100) begin
			tock(1);
			w++;
		end
		check(w, 44);
		tick(1);
		raw <= 1'b0;
	endtask
	task automatic t_wr;
		for (int c = 0; c < 4; c++) lat(2'(c), l[c]);
		check(l[1] + 15, l[0]);
		check(l[2], l[0] + 15);
		check(l[3], l[0]);
		gate <= 1'b0;
		nf = 0;
		pulse();
		tick(100);
		check(nf, 0);
		gate <= 1'b1;
		tick(8);
		nf = 0;
		repeat (4) pulse();
		tock(1);
		check(rdy, 1'b0);
		tick(300);
		check(nf, 3);
		check(rdy, 1'b1);
	endtask
	task automatic t_misc;
		for (int i = 0; i < 4; i++) begin
			tick(1);
			acc <= 1'b1;
			addr <= 10'h3F3 + 10'(i);
			tick(2);
			tock(1);
			check(sel_n, i != 1 && i != 2);
			tick(1);
			acc <= 1'b0;
			rd_n <= i[0];
			tick(8);
			tock(1);
			check(brd, !i[0]);
		end
		// Strobe in primary mode must leave the address bit low
		tick(1);
		stb_n <= 1'b0;
		tick(6);
		stb_n <= 1'b1;
		tick(8);
		tock(1);
		check(aux, 1'b0);
	endtask
	task automatic t_alt;
		tick(1);
		alt <= 1'b1;
		valid <= 1'b0;
		pc <= 2'h0;
		tick(10);
		raw <= 1'b1;
		tick(8);
		tock(1);
		check(dwn, 1'b0);
		check({core, wrc, pref, dw, fb, brd}, 6'h00);
		for (int v = 0; v < 2; v++) begin
			tick(1);
			raw <= 1'b0;
			st1_n <= v[0];
			stb_n <= 1'b0;
			tick(6);
			stb_n <= 1'b1;
			tick(2);
			st1_n <= ~v[0];
			tick(8);
			tock(1);
			check(aux, v[0]);
		end
		check(dwn, 1'b1);
	endtask
	initial begin
		tick(3);
		rst_n_i <= 1'b1;
		t_clk(1'b1);
		t_clk(1'b0);
		t_misc();
		t_clk(1'b1);
		t_wr();
		t_alt();
		results();
	end
endmodule
`default_nettype wire
